// file: aalc_pkg.sv
/*
 * Constants, register map and state encoding for the ADC automatic
 * level control. Assumes an 8-bit register space and a per-sample tick.
 */
package aalc_pkg;

    // ********************
    // Register map
    // ********************
    localparam logic [7:0] AALC_OFS_ENABLE  = 8'h30;
    localparam logic [7:0] AALC_OFS_RATE    = 8'h31;
    localparam logic [7:0] AALC_OFS_HOLD    = 8'h32;
    localparam logic [7:0] AALC_OFS_NOISE   = 8'h33;
    localparam logic [7:0] AALC_OFS_LOW     = 8'h34;
    localparam logic [7:0] AALC_OFS_HIGH    = 8'h35;
    localparam logic [7:0] AALC_OFS_GLIM    = 8'h36;
    localparam logic [7:0] AALC_OFS_ALIM    = 8'h37;
    localparam logic [7:0] AALC_OFS_CLIP    = 8'h38;

    // Writable bits; reserved bits read as zero
    localparam logic [7:0] AALC_MSK_ENABLE  = 8'h5F;
    localparam logic [7:0] AALC_MSK_HOLD    = 8'h0F;
    localparam logic [7:0] AALC_MSK_LEVEL   = 8'h3F;
    localparam logic [7:0] AALC_MSK_ALIM    = 8'h77;
    localparam logic [7:0] AALC_MSK_CLIP    = 8'h83;

    // Reset values
    localparam logic [7:0] AALC_RST_ENABLE  = 8'h00;
    localparam logic [7:0] AALC_RST_RATE    = 8'h00;
    localparam logic [7:0] AALC_RST_HOLD    = 8'h00;
    localparam logic [7:0] AALC_RST_NOISE   = 8'h3F;
    localparam logic [7:0] AALC_RST_LOW     = 8'h3F;
    localparam logic [7:0] AALC_RST_HIGH    = 8'h00;
    localparam logic [7:0] AALC_RST_GLIM    = 8'hFF;
    localparam logic [7:0] AALC_RST_ALIM    = 8'h71;
    localparam logic [7:0] AALC_RST_CLIP    = 8'h00;

    // Field positions
    localparam int AALC_EN_LSB      = 0;
    localparam int AALC_SYNC_LSB    = 4;
    localparam int AALC_ATTACK_LSB  = 0;
    localparam int AALC_RELEASE_LSB = 4;
    localparam int AALC_ATTEN_LSB   = 0;
    localparam int AALC_GMAX_LSB    = 4;

    // ********************
    // Timing, in hundredths of a sample period; hold base in whole sample periods
    // ********************
    localparam logic [22:0] AALC_TICK_X100     = 23'h000064;
    localparam logic [22:0] AALC_ATTACK_X100   = 23'h0002DD;
    localparam logic [22:0] AALC_RELEASE_X100  = 23'h000B32;
    localparam logic [3:0]  AALC_ATTACK_MAXSH  = 4'hC;
    localparam logic [3:0]  AALC_RELEASE_MAXSH = 4'hA;
    localparam logic [21:0] AALC_HOLD_BASE     = 22'h00003E;
    // One limit code is 6 dB, i.e. four 1.5 dB gain steps
    localparam int          AALC_STEP_SHIFT    = 2;

    typedef enum logic [4:0] {
        AALC_ST_OFF     = 5'b00001,
        AALC_ST_TRACK   = 5'b00010,
        AALC_ST_HOLD    = 5'b00100,
        AALC_ST_RELEASE = 5'b01000,
        AALC_ST_ATTACK  = 5'b10000
    } aalc_state_type;

endpackage

// file: aalc_top.sv
/*
 * ADC automatic level control: register file and four channel loops.
 * Assumes register accesses, sample tick and level codes all come from
 * logic on i_ref_clk; levels are 1.5 dB attenuation codes (0 = 0 dBFS).
 */
// Function
// - Four enable bits switch the level loop on per ADC channel.
// - Enable zero keeps the loop idle; all loops disabled after reset.
// - Bits 7:4 pick hybrid analog/digital gain, bits 0 and 2 only.
// - Release code sets gain raise rate, 28.66 doubling, capped 29348.
// - Attack code sets gain cut rate, 7.33 doubling, capped 30024.
// - Hold code sets wait before raising, 62 doubling per code.
// - Inputs quieter than the noise threshold never change the gain.
// - Output below minimum target makes the loop raise the gain.
// - Release, attack and hold reset to code zero.
// - Output above maximum target makes the loop cut the gain.
// - Gain and attenuation are capped in 6 dB steps up to 90 dB.
`timescale 1ns/100ps

module aalc_channel
    import aalc_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    // Controls
    input  wire logic              i_tick,
    input  wire logic              i_en,
    input  wire logic [3:0]        i_attack,
    input  wire logic [3:0]        i_release,
    input  wire logic [3:0]        i_hold,
    input  wire logic [5:0]        i_noise,
    input  wire logic [5:0]        i_low,
    input  wire logic [5:0]        i_high,
    input  wire logic [3:0]        i_gain_max,
    input  wire logic [3:0]        i_atten_max,
    // Levels
    input  wire logic [5:0]        i_in_level,
    input  wire logic [5:0]        i_out_level,
    // Result
    output logic signed [7:0]      o_gain
);

    typedef struct packed {
        aalc_state_type   state;
        logic signed [7:0] gain;
        logic [21:0]      hold_cnt;
        logic [22:0]      acc;
    } aalc_chan_type;

    aalc_chan_type q;
    aalc_chan_type next_q;

    logic signed [7:0] gmax, amin;
    logic [22:0]       aper, rper;
    logic [21:0]       hper;

    // ********************
    // Loop
    // ********************
    always_comb begin
        gmax = $signed(8'(i_gain_max) << AALC_STEP_SHIFT);
        amin = -$signed(8'(i_atten_max) << AALC_STEP_SHIFT);
        aper = AALC_ATTACK_X100 << ((i_attack > AALC_ATTACK_MAXSH) ?
               AALC_ATTACK_MAXSH : i_attack);
        rper = AALC_RELEASE_X100 << ((i_release > AALC_RELEASE_MAXSH) ?
               AALC_RELEASE_MAXSH : i_release);
        hper = AALC_HOLD_BASE << i_hold;
        next_q = q;
        if (!i_en) begin
            next_q = '0;
            next_q.state = AALC_ST_OFF;
        end else if (i_tick) begin
            if (q.state == AALC_ST_OFF) begin
                next_q.state = AALC_ST_TRACK;
            end
            if (i_in_level > i_noise) begin
                // Input under the noise floor: gain and timers freeze
            end else if (i_out_level < i_high) begin
                next_q.hold_cnt = '0;
                next_q.acc = (q.state == AALC_ST_ATTACK) ?
                             q.acc + AALC_TICK_X100 : AALC_TICK_X100;
                next_q.state = AALC_ST_ATTACK;
                if (next_q.acc >= aper) begin
                    next_q.acc = '0;
                    if (q.gain > amin) begin
                        next_q.gain = q.gain - 8'sh01;
                    end
                end
            end else if (i_out_level > i_low) begin
                case (q.state)
                    AALC_ST_HOLD: begin
                        next_q.hold_cnt = q.hold_cnt + 22'h000001;
                        if (next_q.hold_cnt >= hper) begin
                            next_q.state = AALC_ST_RELEASE;
                            next_q.acc = '0;
                        end
                    end
                    AALC_ST_RELEASE: begin
                        next_q.acc = q.acc + AALC_TICK_X100;
                        if (next_q.acc >= rper) begin
                            next_q.acc = '0;
                            if (q.gain < gmax) begin
                                next_q.gain = q.gain + 8'sh01;
                            end
                        end
                    end
                    default: begin
                        next_q.state = AALC_ST_HOLD;
                        next_q.hold_cnt = '0;
                        next_q.acc = '0;
                    end
                endcase
            end else begin
                next_q.state = AALC_ST_TRACK;
                next_q.hold_cnt = '0;
                next_q.acc = '0;
            end
        end
        // Limits may be lowered while running; pull gain back at once
        if (next_q.gain > gmax) begin
            next_q.gain = gmax;
        end else if (next_q.gain < amin) begin
            next_q.gain = amin;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '{state: AALC_ST_OFF, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign o_gain = q.gain;

    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_steady_limits;
        $stable(i_gain_max) && $stable(i_atten_max);
    endsequence
    property p_off_zero;
        !i_en |=> q.gain == 8'sh00 && q.state == AALC_ST_OFF;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("gain not cleared while loop disabled");
    property p_gain_cap;
        s_steady_limits |-> q.gain <= gmax && q.gain >= amin;
    endproperty
    a_gain_cap: assert property (p_gain_cap)
        else $error("gain outside its limits");
    property p_gate;
        i_en && i_tick && i_in_level > i_noise && q.state != AALC_ST_OFF
        ##0 s_steady_limits ##1 s_steady_limits |-> $stable(q.gain);
    endproperty
    a_gate: assert property (p_gate)
        else $error("gain moved on gated input");
    property p_rise_only_release;
        s_steady_limits ##1 i_en && $past(i_en) && q.gain > $past(q.gain)
        |-> $past(q.state) == AALC_ST_RELEASE && $past(i_tick);
    endproperty
    a_rise_only_release: assert property (p_rise_only_release)
        else $error("gain rose outside release");
    property p_attack_no_rise;
        i_en && q.state == AALC_ST_ATTACK ##0 s_steady_limits
        |=> q.gain <= $past(q.gain);
    endproperty
    a_attack_no_rise: assert property (p_attack_no_rise)
        else $error("gain rose during attack");
    property p_one_step;
        i_en ##0 s_steady_limits |=> q.gain - $past(q.gain) <= 8'sh01 &&
        $past(q.gain) - q.gain <= 8'sh01;
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("gain moved more than one step");
    property p_fast_attack;
        i_en && i_attack == 4'h0 && i_tick && i_in_level <= i_noise &&
        i_out_level < i_high && q.state == AALC_ST_ATTACK && q.acc >=
        AALC_ATTACK_X100 - AALC_TICK_X100 && q.gain > amin
        ##0 s_steady_limits |=> q.gain == $past(q.gain) - 8'sh01;
    endproperty
    a_fast_attack: assert property (p_fast_attack)
        else $error("attack step missed");

endmodule // aalc_channel

module aalc_top
    import aalc_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    // Register port
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic                  i_reg_rd,
    output logic [7:0]                 o_reg_rdata,
    // Audio path
    input  wire logic                  i_sample_tick,
    input  wire logic [6*CHANNELS-1:0] i_in_level,
    input  wire logic [6*CHANNELS-1:0] i_out_level,
    output logic [8*CHANNELS-1:0]      o_gain,
    output logic [CHANNELS-1:0]        o_hybrid
);

    typedef struct packed {
        logic [7:0]          enable;
        logic [7:0]          rate;
        logic [7:0]          hold;
        logic [7:0]          noise;
        logic [7:0]          low;
        logic [7:0]          high;
        logic [7:0]          glim;
        logic [7:0]          alim;
        logic [7:0]          clip;
        logic [7:0]          rdata;
        logic [CHANNELS-1:0] hybrid;
    } aalc_regs_type;

    aalc_regs_type q;
    aalc_regs_type next_q;

    // ********************
    // Register file
    // ********************
    always_comb begin
        next_q = q;
        if (i_reg_wr) begin
            if (i_reg_addr == AALC_OFS_ENABLE) begin
                next_q.enable = i_reg_wdata & AALC_MSK_ENABLE;
            end else if (i_reg_addr == AALC_OFS_RATE) begin
                next_q.rate = i_reg_wdata;
            end else if (i_reg_addr == AALC_OFS_HOLD) begin
                next_q.hold = i_reg_wdata & AALC_MSK_HOLD;
            end else if (i_reg_addr == AALC_OFS_NOISE) begin
                next_q.noise = i_reg_wdata & AALC_MSK_LEVEL;
            end else if (i_reg_addr == AALC_OFS_LOW) begin
                next_q.low = i_reg_wdata & AALC_MSK_LEVEL;
            end else if (i_reg_addr == AALC_OFS_HIGH) begin
                next_q.high = i_reg_wdata & AALC_MSK_LEVEL;
            end else if (i_reg_addr == AALC_OFS_GLIM) begin
                next_q.glim = i_reg_wdata;
            end else if (i_reg_addr == AALC_OFS_ALIM) begin
                next_q.alim = i_reg_wdata & AALC_MSK_ALIM;
            end else if (i_reg_addr == AALC_OFS_CLIP) begin
                next_q.clip = i_reg_wdata & AALC_MSK_CLIP;
            end
        end
        // Unmapped addresses read as zero
        next_q.rdata = 8'h00;
        if (i_reg_rd) begin
            if (i_reg_addr == AALC_OFS_ENABLE) begin
                next_q.rdata = q.enable;
            end else if (i_reg_addr == AALC_OFS_RATE) begin
                next_q.rdata = q.rate;
            end else if (i_reg_addr == AALC_OFS_HOLD) begin
                next_q.rdata = q.hold;
            end else if (i_reg_addr == AALC_OFS_NOISE) begin
                next_q.rdata = q.noise;
            end else if (i_reg_addr == AALC_OFS_LOW) begin
                next_q.rdata = q.low;
            end else if (i_reg_addr == AALC_OFS_HIGH) begin
                next_q.rdata = q.high;
            end else if (i_reg_addr == AALC_OFS_GLIM) begin
                next_q.rdata = q.glim;
            end else if (i_reg_addr == AALC_OFS_ALIM) begin
                next_q.rdata = q.alim;
            end else if (i_reg_addr == AALC_OFS_CLIP) begin
                next_q.rdata = q.clip;
            end
        end
        // Channel pairs share the hybrid bit of their ADC
        for (int i = 0; i < CHANNELS; i++) begin
            next_q.hybrid[i] = q.enable[AALC_EN_LSB + i] &
                q.enable[AALC_SYNC_LSB + (i / 2) * 2];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '{enable: AALC_RST_ENABLE, rate: AALC_RST_RATE,
                   hold: AALC_RST_HOLD, noise: AALC_RST_NOISE,
                   low: AALC_RST_LOW, high: AALC_RST_HIGH,
                   glim: AALC_RST_GLIM, alim: AALC_RST_ALIM,
                   clip: AALC_RST_CLIP, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign o_reg_rdata = q.rdata;
    assign o_hybrid    = q.hybrid;

    // ********************
    // Channel loops
    // ********************
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        aalc_channel u_chan (
            .i_ref_clk   (i_ref_clk),
            .i_rst_b     (i_rst_b),
            .i_tick      (i_sample_tick),
            .i_en        (q.enable[AALC_EN_LSB + c]),
            .i_attack    (q.rate[AALC_ATTACK_LSB +: 4]),
            .i_release   (q.rate[AALC_RELEASE_LSB +: 4]),
            .i_hold      (q.hold[3:0]),
            .i_noise     (q.noise[5:0]),
            .i_low       (q.low[5:0]),
            .i_high      (q.high[5:0]),
            .i_gain_max  (q.glim[AALC_GMAX_LSB +: 4]),
            .i_atten_max (q.glim[AALC_ATTEN_LSB +: 4]),
            .i_in_level  (i_in_level[6*c +: 6]),
            .i_out_level (i_out_level[6*c +: 6]),
            .o_gain      (o_gain[8*c +: 8])
        );
    end

    property p_reset_vals;
        @(posedge i_ref_clk) $rose(i_rst_b) |-> q.enable == AALC_RST_ENABLE
        && q.rate == AALC_RST_RATE && q.hold == AALC_RST_HOLD;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("control not at reset values");
    property p_hybrid_map;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        q.enable[AALC_EN_LSB + 1] && q.enable[AALC_SYNC_LSB]
        |=> o_hybrid[1];
    endproperty
    a_hybrid_map: assert property (p_hybrid_map)
        else $error("hybrid select not applied");

endmodule // aalc_top

// file: test_aalc_top.sv
/*
 * Self-checking testbench for the ADC automatic level control top.
 * Assumes aalc_pkg.sv and aalc_top.sv are compiled before this file.
 */
`timescale 1ns/100ps

module test_aalc_top;

    // ********************
    // Stimulus and observation signals
    // ********************
    logic        ref_clk;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        sample_tick;
    logic [23:0] in_level;
    logic [23:0] out_level;
    logic [31:0] gain;
    logic [3:0]  hybrid;
    int          err_total;
    int          comparisons;
    logic [7:0]  rv;

    aalc_top #(.CHANNELS(4)) u_aalc_top (
        .i_ref_clk     (ref_clk),
        .i_rst_b       (rst_b),
        .i_reg_addr    (reg_addr),
        .i_reg_wr      (reg_wr),
        .i_reg_wdata   (reg_wdata),
        .i_reg_rd      (reg_rd),
        .o_reg_rdata   (reg_rdata),
        .i_sample_tick (sample_tick),
        .i_in_level    (in_level),
        .i_out_level   (out_level),
        .o_gain        (gain),
        .o_hybrid      (hybrid)
    );

    always #5 ref_clk = ~ref_clk;

    // ********************
    // Shared tasks
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // A gap cycle follows each write, so strobes never re-rise in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Exactly n tick edges, then a few idle cycles for the output flop
    task automatic run_ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            sample_tick <= 1'b1;
        end
        @(posedge ref_clk);
        sample_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic test_reset_values();
        logic [7:0] rst_val [9];
        rst_val = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h00, 8'hFF,
                    8'h71, 8'h00};
        for (int i = 0; i < 9; i++) begin
            rd(8'h30 + 8'(i), rv);
            check(32'(rv), 32'(rst_val[i]));
        end
        check(gain, 32'h0);
    endtask

    // Reserved bits must read back as zero; unmapped space stays empty
    task automatic test_masks();
        logic [7:0] msk [9];
        msk = '{8'h5F, 8'hFF, 8'h0F, 8'h3F, 8'h3F, 8'h3F, 8'hFF,
                8'h77, 8'h83};
        for (int i = 0; i < 9; i++) begin
            wr(8'h30 + 8'(i), 8'hFF);
            rd(8'h30 + 8'(i), rv);
            check(32'(rv), 32'(msk[i]));
        end
        wr(8'h39, 8'hFF);
        rd(8'h39, rv);
        check(32'(rv), 32'h0);
        rd(8'h2F, rv);
        check(32'(rv), 32'h0);
    endtask

    task automatic test_hybrid();
        logic [7:0] wv [3];
        logic [3:0] ev [3];
        wv = '{8'h5F, 8'h1E, 8'h45};
        ev = '{4'hF, 4'h2, 4'h4};
        for (int i = 0; i < 3; i++) begin
            wr(8'h30, wv[i]);
            repeat (2) @(posedge ref_clk);
            #1;
            check(32'(hybrid), 32'(ev[i]));
        end
    endtask

    // Ch0 loud, ch1 in window, ch2 gated by noise, ch3 loud but disabled
    task automatic test_attack();
        int na [3];
        na = '{8, 15, 30};
        wr(8'h33, 8'h10);
        wr(8'h35, 8'h10);
        wr(8'h34, 8'h20);
        wr(8'h32, 8'h00);
        wr(8'h36, 8'hFF);
        @(posedge ref_clk);
        out_level <= {6'h05, 6'h05, 6'h18, 6'h05};
        in_level  <= {6'h00, 6'h20, 6'h00, 6'h00};
        for (int k = 0; k < 3; k++) begin
            wr(8'h30, 8'h00);
            wr(8'h31, 8'(k));
            wr(8'h30, 8'h07);
            run_ticks(na[k] - 1);
            check(gain, 32'h0);
            run_ticks(2);
            check(gain, 32'h0000_00FF);
        end
    endtask

    task automatic test_atten_cap();
        wr(8'h31, 8'h00);
        wr(8'h36, 8'hF0);
        wr(8'h30, 8'h00);
        wr(8'h30, 8'h01);
        run_ticks(20);
        check(gain, 32'h0);
        wr(8'h36, 8'hF1);
        run_ticks(60);
        check(gain, 32'h0000_00FC);
    endtask

    // First raise comes after one entry tick, the hold, then the release
    task automatic test_release();
        logic [7:0] rr [3];
        logic [7:0] hh [3];
        int         nr [3];
        rr = '{8'h00, 8'h10, 8'h00};
        hh = '{8'h00, 8'h00, 8'h01};
        nr = '{92, 121, 154};
        wr(8'h36, 8'hFF);
        @(posedge ref_clk);
        out_level <= {4{6'h30}};
        in_level  <= 24'h0;
        for (int k = 0; k < 3; k++) begin
            wr(8'h30, 8'h00);
            wr(8'h31, rr[k]);
            wr(8'h32, hh[k]);
            wr(8'h30, 8'h01);
            run_ticks(nr[k] - 2);
            check(gain, 32'h0);
            run_ticks(4);
            check(gain, 32'h0000_0001);
        end
        wr(8'h36, 8'h0F);
        run_ticks(10);
        check(gain, 32'h0);
    endtask

    // All four loops restart fresh, so each has made exactly one raise
    task automatic test_mid_reset();
        wr(8'h36, 8'hFF);
        wr(8'h30, 8'h00);
        wr(8'h32, 8'h00);
        wr(8'h30, 8'h5F);
        run_ticks(100);
        check(gain, 32'h0101_0101);
        wr(8'h31, 8'hA5);
        wr(8'h32, 8'h05);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(gain, 32'h0);
        check(32'(hybrid), 32'h0);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(8'h31, rv);
        check(32'(rv), 32'h0);
        rd(8'h32, rv);
        check(32'(rv), 32'h0);
        rd(8'h30, rv);
        check(32'(rv), 32'h0);
    endtask

    // ********************
    // Main sequence and watchdog
    // ********************
    initial begin
        ref_clk     = 1'b0;
        rst_b       = 1'b0;
        reg_addr    = 8'h00;
        reg_wr      = 1'b0;
        reg_wdata   = 8'h00;
        reg_rd      = 1'b0;
        sample_tick = 1'b0;
        in_level    = 24'h0;
        out_level   = 24'h0;
        err_total   = 0;
        comparisons = 0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        test_reset_values();
        test_masks();
        test_hybrid();
        test_attack();
        test_atten_cap();
        test_release();
        test_mid_reset();
        give_verdict();
    end

    // Whole run needs under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        give_verdict();
    end

endmodule // test_aalc_top
